// ### spi_config_pkg.sv
// Constants, field layouts and state types of the SPI configuration register banks
package spi_config_pkg;

   localparam int CH_NUM = 6;
   localparam int DUTY_W = 9;
   localparam int TIMING_W = 7;
   localparam int PWM_W = 10;
   localparam logic [4:0] FRAME_LEN = 5'h10;
   localparam logic [4:0] CNT_MAX = 5'h11;
   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int WR_POS = 15;
   localparam int BANK_POS = 14;
   localparam int ADDR_LSB = 10;
   localparam int DATA_W = 10;
   localparam int RD_DIAG_POS = 0;
   localparam int DIAG_LIMP_POS = 14;
   localparam int DIAG_BYPASS_POS = 13;
   localparam int DIAG_CLK_LOST_POS = 11;
   // ----------------------------------------------------------------
   // Addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_OUTPUT_SWITCH = 4'h0;
   localparam logic [3:0] ADDR_PWM_CONTROL = 4'h7;
   localparam logic [3:0] ADDR_DUTY_FIRST = 4'h8;
   localparam logic [3:0] ADDR_INPUT_CONFIG = 4'h1;
   localparam logic [3:0] ADDR_HW_CONFIG = 4'h2;
   localparam logic [3:0] ADDR_DIAG_CONTROL = 4'h3;
   localparam logic [3:0] ADDR_TIMING_FIRST = 4'h8;
   localparam logic [3:0] ADDR_CH_LAST = 4'hD;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int AUTO_PWM_POS = 0;
   localparam int DEV_SHIFT_LSB = 1;
   localparam int ONE_DUTY_POS = 3;
   localparam int DIAG_REMAP_POS = 0;
   localparam int OL_LEVEL_POS = 1;
   localparam int DRIVE_CFG_POS = 2;
   localparam int COL_POS = 3;
   localparam int CLEAR_POS = 0;
   localparam int RST_POS = 1;
   localparam int LED_LSB = 2;
   localparam int CLK_POS = 5;
   localparam int TRIM_LSB = 6;
   localparam int MUX_LSB = 0;
   localparam int OL_SWITCH_POS = 3;
   localparam int AUTO_SCAN_POS = 4;
   localparam int FREQ_LSB = 0;
   localparam int SYNC_DLY_LSB = 2;
   localparam int CH_SHIFT_LSB = 4;
   // ----------------------------------------------------------------
   // PWM timing
   // ----------------------------------------------------------------
   localparam int DEV_SHIFT_SCALE = 3;
   localparam int CH_SHIFT_SCALE = 5;
   localparam int SYNC_DLY_SCALE = 3;
   localparam logic [1:0] FREQ_NORMAL = 2'h0;
   localparam logic [1:0] FREQ_DIV256 = 2'h1;
   localparam logic [1:0] FREQ_DIV512 = 2'h2;
   localparam logic [2:0] MUX_EXT_A = 3'h4;
   localparam logic [2:0] MUX_EXT_B = 3'h5;
   localparam logic [2:0] TRIM_RST = 3'h4;

   typedef enum logic [1:0] {LINK_IDLE = 2'h0, LINK_SHIFT = 2'h1, LINK_EXEC = 2'h3} link_state_e;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } spi_in_s;

   typedef struct packed {
      logic limp_home_active;
      logic bypass_monitor;
      logic clock_lost;
      logic standby_flag;
   } status_in_s;

   typedef struct packed {
      logic [CH_NUM-1:0] channel_on_bit;
      logic auto_pwm_enable;
      logic [1:0] device_phase_shift;
      logic single_duty_select;
      logic [CH_NUM-1:0][DUTY_W-1:0] duty_value;
      logic input_combine_and;
      logic input_drive_config;
      logic open_load_source_level;
      logic driver_diag_remap;
      logic [2:0] osc_trim;
      logic clock_internal;
      logic [1:0] led_mode_bit;
      logic auto_sense_scan;
      logic open_load_source_switch;
      logic [2:0] sense_route_select;
      logic [CH_NUM-1:0][TIMING_W-1:0] timing;
   } cfg_s;

   localparam cfg_s CFG_RST = '{osc_trim: TRIM_RST, default: '0};

   typedef struct packed {
      link_state_e state;
      logic sclk_prev;
      logic pclk_prev;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic [4:0] bit_cnt;
      logic so_bit;
      logic so_drive;
      logic transfer_error_flag;
      logic resp_diag;
      logic resp_bank;
      logic [3:0] resp_addr;
      cfg_s cfg;
      logic [CH_NUM-1:0] fault;
      logic clear_pulse;
      logic soft_reset;
      logic [7:0] osc_cnt;
      logic [PWM_W-1:0] pwm_cnt;
      logic [CH_NUM-1:0] chan;
      logic [CH_NUM-1:0] sync;
   } state_s;

endpackage

// ### spi_config_register_banks.sv
// SPI-addressed configuration banks, PWM engine and channel drive logic
//
// Operation
// - Bank-select bit picks bank 0 or 1; address picks register for data.
// - Bank 0 address 0 holds one on/off bit per channel 5..0.
// - Bank 0 address 7 bit 0 enables automatic PWM generation.
// - Single-duty bit 0 applies channel 0 duty to all channels.
// - Two-bit device phase shift delays PWM by 0, 8, 16 or 24 ticks.
// - Six 9-bit duty registers at bank 0 addresses 8 to 13.
// - Duty zero keeps channel off; k keeps it on k/256 of period.
// - Duty MSB set keeps the channel on for the whole period.
// - Reading an unmapped address returns the standard diagnosis word.
// - Remap bit turns external diagnosis outputs into enable and select.
// - Open-load source level bit: 0 low level, 1 high level.
// - Combine bit 0: channel driven by input pin OR switch bit.
// - Combine bit 1: channel driven by input pin AND switch bit.
// - Writing clear-latch 1 clears all fault latches; 0 leaves them.
// - Writing reset-command 1 executes a device reset.
// - Reading that bit shows standby status instead.
// - Channels 3 and 2 each have bulb (0) or LED (1) mode bit.
// - Prescaler: normal, or PWM period of 256, 512, 1024 ticks.
// - Channel phase shift delays PWM start by field times 32 ticks.
// - Sync delay moves sense sync pulse by 0, 8, 16 or 24 ticks.
// - Clock-mode bit: 0 external PWM clock, 1 internal oscillator.
`timescale 1ns/1ps
module spi_config_register_banks
#(
   parameter int INT_OSC_DIV = 10
)
(
   input wire logic clock_in, // 100 MHz system clock
   input wire logic reset_n_in, // Asynchronous reset, active low
   input wire spi_config_pkg::spi_in_s spi_in, // Chip select, serial clock, serial in
   output logic spi_so_out, // Serial data out
   output logic spi_so_oe_n_out, // Serial out enable, low while driving
   input wire logic pclk_in, // External PWM clock
   input wire logic [5:0] channel_in_in, // Channel input pins
   input wire logic [5:0] fault_event_in, // Thermal or over-current events
   input wire spi_config_pkg::status_in_s status_in, // Analog status flags
   output logic [5:0] channel_on_out, // Channel drive
   output logic [5:0] sense_sync_out, // Current sense sync pulses
   output logic [5:0] fault_latch_out, // Fault latches
   output logic soft_reset_out, // Device reset command pulse
   output logic [1:0] led_mode_out, // LED mode of channels 3..2
   output logic open_load_level_out, // Open-load source level
   output logic open_load_switch_out, // Open-load source on
   output logic input_assigned_out, // Assigned input drive mode
   output logic [2:0] sense_route_out, // Sense multiplexer code
   output logic auto_scan_out, // Automatic sense scan
   output logic [2:0] osc_trim_out, // Internal clock trim
   output logic clock_internal_out, // PWM clock source select
   output logic ext_driver_diag_a_out, // External driver diagnosis A
   output logic ext_driver_diag_b_out // External driver diagnosis B
);
   import spi_config_pkg::*;

   state_s q;
   state_s d;
   logic tick;
   logic [CH_NUM-1:0] pwm_on_w;
   logic [CH_NUM-1:0] sync_w;
   logic [15:0] diag_word;
   logic [10:0] rd;

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // Returns {hit, data}; status bits come from live inputs
   function automatic logic [10:0] read_reg(input cfg_s c, input logic bank,
                                            input logic [3:0] addr, input status_in_s st);
      logic [9:0] v;
      logic hit;
      int idx;
      v = '0;
      hit = 1'b1;
      idx = int'(addr - ADDR_DUTY_FIRST);
      if (!bank)
      begin
         if (addr == ADDR_OUTPUT_SWITCH)
            v[CH_NUM-1:0] = c.channel_on_bit;
         else if (addr == ADDR_PWM_CONTROL)
         begin
            v[AUTO_PWM_POS] = c.auto_pwm_enable;
            v[DEV_SHIFT_LSB +: 2] = c.device_phase_shift;
            v[ONE_DUTY_POS] = c.single_duty_select;
         end
         else if (addr >= ADDR_DUTY_FIRST && addr <= ADDR_CH_LAST)
            v[DUTY_W-1:0] = c.duty_value[idx];
         else
            hit = 1'b0;
      end
      else
      begin
         if (addr == ADDR_INPUT_CONFIG)
         begin
            v[DIAG_REMAP_POS] = c.driver_diag_remap;
            v[OL_LEVEL_POS] = c.open_load_source_level;
            v[DRIVE_CFG_POS] = c.input_drive_config;
            v[COL_POS] = c.input_combine_and;
         end
         else if (addr == ADDR_HW_CONFIG)
         begin
            v[RST_POS] = st.standby_flag;
            v[LED_LSB +: 2] = c.led_mode_bit;
            v[CLK_POS] = c.clock_internal;
            v[TRIM_LSB +: 3] = c.osc_trim;
         end
         else if (addr == ADDR_DIAG_CONTROL)
         begin
            v[MUX_LSB +: 3] = c.sense_route_select;
            v[OL_SWITCH_POS] = st.bypass_monitor;
            v[AUTO_SCAN_POS] = c.auto_sense_scan;
         end
         else if (addr >= ADDR_TIMING_FIRST && addr <= ADDR_CH_LAST)
            v[TIMING_W-1:0] = c.timing[idx];
         else
            hit = 1'b0;
      end
      return {hit, v};
   endfunction

   always_comb
   begin
      diag_word = '0;
      diag_word[DIAG_LIMP_POS] = status_in.limp_home_active;
      diag_word[DIAG_BYPASS_POS] = status_in.bypass_monitor;
      diag_word[DIAG_CLK_LOST_POS] = status_in.clock_lost;
      diag_word[3:0] = q.fault[3:0];
   end

   assign rd = read_reg(q.cfg, q.resp_bank, q.resp_addr, status_in);

   // ----------------------------------------------------------------
   // PWM tick and per-channel generators
   // ----------------------------------------------------------------
   // Internal oscillator is modelled as a divider on the system clock
   assign tick = q.cfg.clock_internal ? (q.osc_cnt == 8'(INT_OSC_DIV - 1))
                                      : (pclk_in && !q.pclk_prev);

   for (genvar i = 0; i < CH_NUM; i++)
   begin : g_ch
      logic [DUTY_W-1:0] duty;
      logic [1:0] freq;
      logic [PWM_W-1:0] offs;
      logic [PWM_W-1:0] pos;
      logic [PWM_W-1:0] in_period;
      logic [7:0] scaled;
      assign duty = q.cfg.single_duty_select ? q.cfg.duty_value[i]
                                             : q.cfg.duty_value[0];
      assign freq = q.cfg.timing[i][FREQ_LSB +: 2];
      assign offs = (PWM_W'(q.cfg.device_phase_shift) << DEV_SHIFT_SCALE)
                  + (PWM_W'(q.cfg.timing[i][CH_SHIFT_LSB +: 3]) << CH_SHIFT_SCALE);
      assign pos = q.pwm_cnt - offs;
      always_comb
      begin
         unique case (freq)
            FREQ_DIV256:
            begin
               scaled = pos[7:0];
               in_period = {2'h0, pos[7:0]};
            end
            FREQ_DIV512:
            begin
               scaled = pos[8:1];
               in_period = {1'h0, pos[8:0]};
            end
            default:
            begin
               scaled = pos[9:2];
               in_period = pos;
            end
         endcase
      end
      assign pwm_on_w[i] = duty[DUTY_W-1] || (duty[7:0] > scaled);
      assign sync_w[i] = tick && (freq != FREQ_NORMAL) && (in_period ==
         (PWM_W'(q.cfg.timing[i][SYNC_DLY_LSB +: 2]) << SYNC_DLY_SCALE));
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [15:0] f;
      logic [3:0] a;
      logic [9:0] v;
      int idx;
      logic auto_on;
      d = q;
      f = q.shift_in;
      a = f[ADDR_LSB +: 4];
      v = f[DATA_W-1:0];
      idx = int'(a - ADDR_DUTY_FIRST);
      auto_on = 1'b0;
      d.sclk_prev = spi_in.sclk;
      d.pclk_prev = pclk_in;
      d.clear_pulse = 1'b0;
      d.soft_reset = 1'b0;
      d.osc_cnt = tick && q.cfg.clock_internal ? '0 : q.osc_cnt + 8'h01;
      d.pwm_cnt = q.pwm_cnt + PWM_W'(tick);
      // Serial link
      unique case (q.state)
         LINK_IDLE:
         begin
            if (!spi_in.cs_n)
            begin
               d.state = LINK_SHIFT;
               d.bit_cnt = '0;
               d.so_drive = 1'b1;
               d.so_bit = q.transfer_error_flag;
               d.shift_out = (q.resp_diag || !rd[10]) ? diag_word
                  : {1'b1, q.resp_bank, q.resp_addr, rd[9:0]};
            end
         end
         LINK_SHIFT:
         begin
            if (spi_in.cs_n)
            begin
               d.state = LINK_EXEC;
               d.so_drive = 1'b0;
               d.transfer_error_flag = (q.bit_cnt != FRAME_LEN);
            end
            else if (spi_in.sclk && !q.sclk_prev)
            begin
               d.so_bit = q.shift_out[15];
               d.shift_out = {q.shift_out[14:0], 1'b0};
            end
            else if (!spi_in.sclk && q.sclk_prev)
            begin
               d.shift_in = {q.shift_in[14:0], spi_in.si};
               if (q.bit_cnt != CNT_MAX)
                  d.bit_cnt = q.bit_cnt + 5'h01;
            end
         end
         LINK_EXEC:
         begin
            d.state = LINK_IDLE;
            if (!q.transfer_error_flag)
            begin
               d.resp_diag = 1'b1;
               d.resp_bank = f[BANK_POS];
               d.resp_addr = a;
               if (!f[WR_POS])
                  d.resp_diag = f[RD_DIAG_POS];
               else if (!f[BANK_POS])
               begin
                  if (a == ADDR_OUTPUT_SWITCH)
                     d.cfg.channel_on_bit = v[CH_NUM-1:0];
                  else if (a == ADDR_PWM_CONTROL)
                  begin
                     d.cfg.auto_pwm_enable = v[AUTO_PWM_POS];
                     d.cfg.device_phase_shift = v[DEV_SHIFT_LSB +: 2];
                     d.cfg.single_duty_select = v[ONE_DUTY_POS];
                  end
                  else if (a >= ADDR_DUTY_FIRST && a <= ADDR_CH_LAST)
                     d.cfg.duty_value[idx] = v[DUTY_W-1:0];
               end
               else
               begin
                  if (a == ADDR_INPUT_CONFIG)
                  begin
                     d.cfg.driver_diag_remap = v[DIAG_REMAP_POS];
                     d.cfg.open_load_source_level = v[OL_LEVEL_POS];
                     d.cfg.input_drive_config = v[DRIVE_CFG_POS];
                     d.cfg.input_combine_and = v[COL_POS];
                  end
                  else if (a == ADDR_HW_CONFIG)
                  begin
                     d.clear_pulse = v[CLEAR_POS];
                     d.soft_reset = v[RST_POS];
                     d.cfg.led_mode_bit = v[LED_LSB +: 2];
                     d.cfg.clock_internal = v[CLK_POS];
                     d.cfg.osc_trim = v[TRIM_LSB +: 3];
                  end
                  else if (a == ADDR_DIAG_CONTROL)
                  begin
                     d.cfg.sense_route_select = v[MUX_LSB +: 3];
                     d.cfg.open_load_source_switch = v[OL_SWITCH_POS];
                     d.cfg.auto_sense_scan = v[AUTO_SCAN_POS];
                  end
                  else if (a >= ADDR_TIMING_FIRST && a <= ADDR_CH_LAST)
                     d.cfg.timing[idx] = v[TIMING_W-1:0];
               end
            end
         end
         default:
            d.state = LINK_IDLE;
      endcase
      // Channel drive; auto PWM overrides the input combination
      for (int i = 0; i < CH_NUM; i++)
      begin
         auto_on = q.cfg.auto_pwm_enable
                && (q.cfg.timing[i][FREQ_LSB +: 2] != FREQ_NORMAL);
         if (auto_on)
            d.chan[i] = pwm_on_w[i];
         else if (q.cfg.input_combine_and)
            d.chan[i] = channel_in_in[i] && q.cfg.channel_on_bit[i];
         else
            d.chan[i] = channel_in_in[i] || q.cfg.channel_on_bit[i];
      end
      d.sync = sync_w;
      // Event set wins over a clear in the same cycle
      d.fault = (q.clear_pulse ? '0 : q.fault) | fault_event_in;
      if (q.soft_reset)
      begin
         d.cfg = CFG_RST;
         d.fault = fault_event_in;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         q <= '0;
         q.state <= LINK_IDLE;
         q.cfg <= CFG_RST;
         q.transfer_error_flag <= 1'b1;
         q.resp_diag <= 1'b1;
      end
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign spi_so_out = q.so_bit;
   assign spi_so_oe_n_out = !q.so_drive;
   assign channel_on_out = q.chan;
   assign sense_sync_out = q.sync;
   assign fault_latch_out = q.fault;
   assign soft_reset_out = q.soft_reset;
   assign led_mode_out = q.cfg.led_mode_bit;
   assign open_load_level_out = q.cfg.open_load_source_level;
   assign open_load_switch_out = q.cfg.open_load_source_switch;
   assign input_assigned_out = q.cfg.input_drive_config;
   assign sense_route_out = q.cfg.sense_route_select;
   assign auto_scan_out = q.cfg.auto_sense_scan;
   assign osc_trim_out = q.cfg.osc_trim;
   assign clock_internal_out = q.cfg.clock_internal;
   // Remapped: A is diag enable, B is diag select
   assign ext_driver_diag_a_out = q.cfg.driver_diag_remap
      ? (q.cfg.sense_route_select == MUX_EXT_A || q.cfg.sense_route_select == MUX_EXT_B)
      : (q.cfg.sense_route_select == MUX_EXT_A);
   assign ext_driver_diag_b_out = (q.cfg.sense_route_select == MUX_EXT_B);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   a_short_frame_err: assert property (
      (q.state == LINK_SHIFT && spi_in.cs_n && q.bit_cnt != FRAME_LEN)
      |=> q.transfer_error_flag ##1 $stable(q.cfg))
      else $error("short frame not flagged or applied");
   a_out_write: assert property (
      (q.state == LINK_EXEC && !q.transfer_error_flag && q.shift_in[WR_POS]
       && !q.shift_in[BANK_POS] && q.shift_in[ADDR_LSB +: 4] == ADDR_OUTPUT_SWITCH
       && !q.soft_reset)
      |=> q.cfg.channel_on_bit == $past(q.shift_in[CH_NUM-1:0]))
      else $error("output switch write lost");
   a_clear_latch: assert property (
      (q.clear_pulse && !q.soft_reset && fault_event_in == '0) |=> fault_latch_out == '0)
      else $error("fault latches not cleared");
   a_set_wins: assert property (
      fault_event_in[0] |=> fault_latch_out[0])
      else $error("fault event lost");
   a_soft_reset: assert property (
      soft_reset_out |=> q.cfg == CFG_RST)
      else $error("soft reset did not restore settings");
   a_full_duty: assert property (
      (q.cfg.auto_pwm_enable && q.cfg.timing[0][FREQ_LSB +: 2] != FREQ_NORMAL
       && q.cfg.duty_value[0][DUTY_W-1]) |=> channel_on_out[0])
      else $error("full duty not on");
   a_zero_duty: assert property (
      (q.cfg.auto_pwm_enable && q.cfg.timing[0][FREQ_LSB +: 2] != FREQ_NORMAL
       && q.cfg.duty_value[0] == '0) |=> !channel_on_out[0])
      else $error("zero duty not off");
   a_and_combine: assert property (
      (!q.cfg.auto_pwm_enable && q.cfg.input_combine_and && !channel_in_in[1])
      |=> !channel_on_out[1])
      else $error("and combine drives channel");
   a_or_combine: assert property (
      (!q.cfg.auto_pwm_enable && !q.cfg.input_combine_and && q.cfg.channel_on_bit[1])
      |=> channel_on_out[1])
      else $error("or combine misses switch bit");
   a_so_driven: assert property (
      (q.state == LINK_IDLE && !spi_in.cs_n) |=> !spi_so_oe_n_out [*2])
      else $error("serial out not driven in frame");

   c_write_frame: cover property (q.state == LINK_EXEC && !q.transfer_error_flag
                                  && q.shift_in[WR_POS]);
   c_read_frame: cover property (q.state == LINK_EXEC && !q.transfer_error_flag
                                 && !q.shift_in[WR_POS]);
   c_error_frame: cover property (q.state == LINK_EXEC && q.transfer_error_flag);
   c_sync_pulse: cover property (sense_sync_out[0]);

endmodule

// ### spi_config_register_banks_tb.sv
// Self-checking bench of the configuration register banks
`timescale 1ns/1ps
module spi_config_register_banks_tb;
   import spi_config_pkg::*;
   logic clock_in, reset_n_in, pclk_in, so, done, srst, lvl;
   logic olsw, scan, dga, dgb, asg;
   logic [2:0] trim, route;
   logic [5:0] pins, faults, chan, latch, sw, sync;
   logic [1:0] led;
   logic [16:0] rx;
   logic [33:0] exp_q[$];
   spi_in_s spi;
   status_in_s st;
   int err_count, comparisons, seed, n, hi, sy;
   spi_config_register_banks i_spi_config_register_banks (.clock_in(clock_in),
      .reset_n_in(reset_n_in), .spi_in(spi), .spi_so_out(so), .spi_so_oe_n_out(),
      .pclk_in(pclk_in), .channel_in_in(pins), .fault_event_in(faults), .status_in(st),
      .channel_on_out(chan), .sense_sync_out(sync), .fault_latch_out(latch),
      .soft_reset_out(srst), .led_mode_out(led), .open_load_level_out(lvl),
      .open_load_switch_out(olsw), .input_assigned_out(asg), .sense_route_out(route),
      .auto_scan_out(scan), .osc_trim_out(trim), .clock_internal_out(),
      .ext_driver_diag_a_out(dga), .ext_driver_diag_b_out(dgb));
   spi_master_model i_spi_master_model (.clock_in(clock_in), .so_in(so), .spi_out(spi),
      .rx_out(rx), .done_out(done));
   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic compare(input logic [16:0] got, input logic [33:0] e);
      comparisons++;
      if (((got ^ e[16:0]) & e[33:17]) !== 17'h0)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, e[16:0]);
      end
   endtask
   task automatic check_port(input logic [16:0] got, input logic [16:0] e);
      compare(got, {17'h1FFFF, e});
   endtask
   task automatic frame(input logic [15:0] w, input logic [33:0] e);
      exp_q.push_back(e);
      i_spi_master_model.xfer(w, 16);
   endtask
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clock_in)
      if (done === 1'b1 && exp_q.size() > 0)
         compare(rx, exp_q.pop_front());
   always @(posedge clock_in)
      if (srst === 1'b1)
         n++;
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial
   begin
      pclk_in = 1'b0;
      forever #20 pclk_in = ~pclk_in;
   end
   initial
   begin
      #400000;
      err_count++;
      wrap_up;
   end
   initial
   begin
      {reset_n_in, pins, faults, st, err_count, comparisons, n} = '0;
      seed = 97541;
      repeat (12) @(posedge clock_in);
      #1 reset_n_in = 1'b1;
      sw = $random(seed);
      pins = $random(seed);
      frame({10'h200, sw}, {17'h1FFFF, 17'h10000});
      frame(16'h0000, {17'h1FFFF, 17'h0});
      check_port(chan, sw | pins);
      frame(16'hC40F, {17'h1FFFF, 11'h200, sw});
      check_port(chan, sw & pins);
      check_port(lvl, 1'b1);
      frame(16'hCC1D, {17'h1FFFF, 17'h0});
      check_port({dga, dgb}, 2'h3);
      check_port({asg, olsw, scan, route}, 6'h3D);
      frame(16'h1000, {17'h1FFFF, 17'h0});
      frame(16'h0001, {17'h1FFFF, 17'h0});
      @(posedge clock_in);
      #1 faults = 6'h05;
      @(posedge clock_in);
      #1 faults = 6'h00;
      frame(16'hC809, {17'h1FFFF, 17'h00005});
      check_port(latch, 6'h00);
      check_port(led, 2'h2);
      st.standby_flag = 1'b1;
      frame(16'h4800, {17'h1FFFF, 17'h0});
      frame(16'h0001, {17'h1FFFE, 17'h0C80A});
      // Only the error flag and the first eight bits come back
      exp_q.push_back({17'h1FF00, 17'h0});
      i_spi_master_model.xfer(16'h803F, 8);
      frame(16'h0000, {17'h1FFFF, 17'h10000});
      frame(16'h0001, {17'h1FFFF, 11'h200, sw});
      frame(16'hC80E, {17'h1FFFF, 17'h0});
      check_port(n[16:0], 17'h1);
      check_port(led, 2'h0);
      check_port({trim, route, olsw, scan, dga, dgb, asg, lvl}, {TRIM_RST, 9'h0});
      frame(16'hE001, {17'h1FFFF, 17'h0});
      frame(16'hA100, {17'h1FFFF, 17'h0});
      frame(16'h9C01, {17'h1FFFF, 17'h0});
      // Two full periods at four cycles per tick
      hi = 0;
      repeat (2100) @(posedge clock_in) hi += chan[0];
      check_port(hi[16:0], 17'd2100);
      frame(16'hA040, {17'h1FFFF, 17'h0});
      // Exactly two periods: 64 of 256 ticks on, one sync pulse each
      hi = 0;
      sy = 0;
      repeat (2048) @(posedge clock_in)
      begin
         hi += chan[0];
         sy += sync[0];
      end
      check_port(hi[16:0], 17'd512);
      check_port(sy[16:0], 17'd2);
      frame(16'hA000, {17'h1FFFF, 17'h0});
      hi = 0;
      repeat (2100) @(posedge clock_in) hi += chan[0];
      check_port(hi[16:0], 17'd0);
      wrap_up;
   end
endmodule

// ### spi_master_model.sv
// SPI master model for the configuration link
`timescale 1ns/1ps
module spi_master_model
(
   input wire logic clock_in, // System clock
   input wire logic so_in, // Device serial out
   output spi_config_pkg::spi_in_s spi_out, // Link pins
   output logic [16:0] rx_out, // Error flag and word
   output logic done_out // Word captured
);
   import spi_config_pkg::*;
   initial spi_out = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
   initial done_out = 1'b0;
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   // Bit 15 goes first; a short count makes a broken frame
   task automatic xfer(input logic [15:0] w, input int nb);
      step(1);
      spi_out.cs_n = 1'b0;
      step(2);
      rx_out[16] = so_in;
      for (int i = 0; i < nb; i++)
      begin
         spi_out.si = w[15-i];
         spi_out.sclk = 1'b1;
         step(2);
         rx_out[15-i] = so_in;
         spi_out.sclk = 1'b0;
         step(2);
      end
      spi_out.cs_n = 1'b1;
      // Released line must not keep its last value
      spi_out.si = ~spi_out.si;
      done_out = 1'b1;
      step(1);
      done_out = 1'b0;
      step(3);
   endtask
endmodule
